// *** src/ppr_consts.svh ***
// register offsets, field positions and codes of the peripheral pin remap block
// assumes inclusion by bare name from the top module and the bench
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

// register byte offsets and storage indices
`define PPR_OFF_TIMER   12'h000
`define PPR_OFF_SERIAL  12'h004
`define PPR_OFF_UART    12'h008
`define PPR_OFF_DEBUG   12'h00C
`define PPR_OFF_COMP    12'h010
`define PPR_IDX_TIMER   3'h0
`define PPR_IDX_SERIAL  3'h1
`define PPR_IDX_UART    3'h2
`define PPR_IDX_DEBUG   3'h3
`define PPR_IDX_COMP    3'h4
`define PPR_NREGS       5
`define PPR_RESET_VAL   32'h0000_0000

// writable bits of each register, the rest read as zero
`define PPR_MASK_TIMER  32'h000F_0F7F
`define PPR_MASK_SERIAL 32'h00FF_0FF0
`define PPR_MASK_UART   32'hFF0F_0F0F
`define PPR_MASK_DEBUG  32'h0017_0030
`define PPR_MASK_COMP   32'h0000_00FF

// field positions
`define PPR_T5CH4_BIT   19
`define PPR_T5_F        18:16
`define PPR_T3_F        11:8
`define PPR_T2_F        6:4
`define PPR_T1_F        3:0
`define PPR_SPI2_F      23:20
`define PPR_SPI1_F      19:16
`define PPR_TW2_F       11:8
`define PPR_TW1_F       7:4
`define PPR_UART4_F     31:28
`define PPR_USART3_F    27:24
`define PPR_USART1_F    19:16
`define PPR_SD_F        11:8
`define PPR_CAN_F       3:0
`define PPR_OSC_BIT     20
`define PPR_DBG_F       18:16
`define PPR_ADCREG_BIT  4
`define PPR_ADCPRE_BIT  5
`define PPR_T3C1_F      7:6
`define PPR_T2C4_F      5:4
`define PPR_T1C1_F      3:2
`define PPR_T1BK_F      1:0

// field codes
`define PPR_SET0        4'h0
`define PPR_SET1        4'h1
`define PPR_SET2        4'h2
`define PPR_SET3        4'h3
`define PPR_SD_W8_B     4'h4
`define PPR_SD_W4_B     4'h5
`define PPR_SD_W8_A     4'h6
`define PPR_SD_W4_A     4'h7
`define PPR_T5_ALT      3'h1
`define PPR_T2_MAX      3'h3
`define PPR_DBG_FULL    3'h0
`define PPR_DBG_NORST   3'h1
`define PPR_DBG_SWD     3'h2
`define PPR_DBG_NONE    3'h4
`define PPR_CMP_ONLY    2'h2
`define PPR_CMP_EITHER  2'h3
`define PPR_HSIZE_WORD  3'h2

`endif

// *** src/ppr_pkg.sv ***
// types of the peripheral pin remap block
// assumes the constants header sits beside it
package ppr_pkg;

    // pad and internal levels that arrive from outside the clock domain
    typedef struct packed {
        logic pa3;
        logic pa6;
        logic pa8;
        logic pb4;
        logic pb11;
        logic pb12;
        logic pc6;
        logic cmp_out;
        logic low_speed_internal_clock;
    } ppr_pad_s;

    // pin-set selection toward the pad controller
    typedef struct packed {
        logic       fifth_timer_alt;
        logic       third_timer_alt;
        logic       second_timer_ch12_alt;
        logic       second_timer_ch34_alt;
        logic [1:0] advanced_timer_set;
        logic       second_spi_alt;
        logic       first_spi_alt;
        logic [1:0] second_twowire_set;
        logic [1:0] first_twowire_set;
        logic       fourth_uart_alt;
        logic [1:0] third_usart_set;
        logic       first_usart_alt;
        logic       sd_alt;
        logic       sd_narrow;
        logic       sd_clkcmd_port_a;
        logic       can_alt;
        logic       osc_pad_port_d_map;
        logic       jtag_reset_pin_free;
        logic       jtag_pins_free;
        logic       swd_pins_free;
    } ppr_route_s;

    // internally routed peripheral inputs
    typedef struct packed {
        logic fifth_timer_ch4;
        logic third_timer_ch1;
        logic second_timer_ch4;
        logic advanced_timer_ch1;
        logic advanced_timer_break;
        logic converter_regular_trig;
        logic converter_preempt_trig;
    } ppr_internal_s;

    typedef logic [31:0] ppr_word_t;

endpackage

// *** src/ppr_top.sv ***
// peripheral pin remap: five remap registers on AHB-Lite, pin-set decode and internal routing
// assumes a single AHB-Lite master, pads and comparator asynchronous to hclk
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"

// Summary of operation
// - fifth timer ch4 takes port A pin 3, or low-speed clock when bit set
// - fifth timer code 1 moves channels 1 and 2 to port F pins 4, 5
// - third timer code 1 moves channels 1, 2 to port B pins 4, 5
// - second timer bit 0 moves channels 1-2, bit 1 moves channels 3-4
// - advanced timer has three pin sets 0, 1, 2; other codes unused
// - second SPI on default pins for code 0, alternate pins for code 1
// - first SPI on default pins for code 0, alternate pins for code 1
// - second two-wire controller has four pin sets, codes 0 to 3
// - first two-wire controller has three pin sets, alert never moves
// - fourth UART on port C or port F pins by its top field
// - third USART has three pin sets including clock and flow control
// - first USART on port A pins 9/10 or port B pins 6/7
// - SD card codes 0, 4-7; odd codes four data lines; 011x moves clock
// - CAN on port A pins 11/12 for code 00, port B 8/9 for 10
// - oscillator bit maps port D pins 0, 1 onto crystal pads
// - debug field frees reset, JTAG or all pins; other codes change nothing
// - regular converter trigger from interrupt line 11 or advanced timer trigger
// - preempted converter trigger from advanced timer channel 4 when bit set
// - third timer ch1 from pin, comparator, or either, by two-bit code
// - second timer ch4 from pin, comparator, or either, by two-bit code
// - advanced timer ch1 from pin, comparator, or either, by two-bit code
// - advanced timer break from pin, comparator, or either, by two-bit code
module ppr_top (
    input  wire logic                  hclk,                          // bus clock
    input  wire logic                  hresetn,                       // async reset, active low
    input  wire logic                  hsel,                          // slave select
    input  wire logic [31:0]           haddr,                         // byte address
    input  wire logic [1:0]            htrans,                        // transfer type
    input  wire logic                  hwrite,                        // write when high
    input  wire logic [2:0]            hsize,                         // transfer size
    input  wire logic [31:0]           hwdata,                        // write data
    input  wire logic                  hready,                        // bus ready
    output logic                       hreadyout,                     // always ready
    output logic                       hresp,                         // always okay
    output logic [31:0]                hrdata,                        // read data
    input  wire ppr_pkg::ppr_pad_s     pad_in,                        // pad and comparator levels
    input  wire logic                  advanced_timer_trigger_out,   // timer trigger, same clock
    input  wire logic                  advanced_timer_ch4_out,       // timer channel 4, same clock
    input  wire logic                  ext_interrupt_line_11,        // interrupt line, same clock
    input  wire logic                  converter_preempt_default,    // default preempt trigger
    output var ppr_pkg::ppr_route_s    route,                         // pin-set selection
    output var ppr_pkg::ppr_internal_s internal_in                    // routed peripheral inputs
);
    import ppr_pkg::*;

    localparam int PPR_PAD_W = $bits(ppr_pad_s);

    ppr_word_t                regs_reg [0:`PPR_NREGS-1];
    logic                     wr_pend_reg;
    logic [2:0]               wr_idx_reg;
    logic [PPR_PAD_W-1:0]     pad_meta_reg;
    logic [PPR_PAD_W-1:0]     pad_sync_reg;
    ppr_pad_s                 pad_s;
    ppr_route_s               route_next;
    ppr_internal_s            internal_next;
    logic                     addr_take;
    logic [3:0]               addr_hit;
    ppr_word_t                rd_next;
    logic [3:0]               tw2_f;
    logic [3:0]               tw1_f;
    logic [3:0]               us3_f;
    logic [3:0]               sd_f;
    logic [3:0]               t1_f;
    logic [2:0]               t2_f;

    // map a byte address to {hit, index}
    function automatic logic [3:0] reg_hit(input logic [31:0] addr);
        case (addr[11:0])
            `PPR_OFF_TIMER:  reg_hit = {1'b1, `PPR_IDX_TIMER};
            `PPR_OFF_SERIAL: reg_hit = {1'b1, `PPR_IDX_SERIAL};
            `PPR_OFF_UART:   reg_hit = {1'b1, `PPR_IDX_UART};
            `PPR_OFF_DEBUG:  reg_hit = {1'b1, `PPR_IDX_DEBUG};
            `PPR_OFF_COMP:   reg_hit = {1'b1, `PPR_IDX_COMP};
            default:         reg_hit = 4'h0;
        endcase
    endfunction

    // writable bits per register
    function automatic ppr_word_t mask_of(input logic [2:0] idx);
        case (idx)
            `PPR_IDX_TIMER:  mask_of = `PPR_MASK_TIMER;
            `PPR_IDX_SERIAL: mask_of = `PPR_MASK_SERIAL;
            `PPR_IDX_UART:   mask_of = `PPR_MASK_UART;
            `PPR_IDX_DEBUG:  mask_of = `PPR_MASK_DEBUG;
            `PPR_IDX_COMP:   mask_of = `PPR_MASK_COMP;
            default:         mask_of = `PPR_RESET_VAL;
        endcase
    endfunction

    // pin, comparator or their OR, shared by four routes
    function automatic logic comp_route(input logic [1:0] code, input logic pin, input logic cmp);
        case (code)
            `PPR_CMP_ONLY:   comp_route = cmp;
            `PPR_CMP_EITHER: comp_route = cmp | pin;
            default:         comp_route = pin;
        endcase
    endfunction

    // address phase decode; the slave never inserts wait states
    assign addr_take = hsel && htrans[1] && hready;
    assign addr_hit  = reg_hit(haddr);

    // write address captured; data lands on the following edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 3'h0;
        end else begin
            wr_pend_reg <= addr_take && hwrite && addr_hit[3] && (hsize == `PPR_HSIZE_WORD);
            wr_idx_reg  <= addr_hit[2:0];
        end
    end

    // register storage; reserved bits never stored so they read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `PPR_NREGS; i++) begin
                regs_reg[i] <= `PPR_RESET_VAL;
            end
        end else if (wr_pend_reg) begin
            regs_reg[wr_idx_reg] <= hwdata & mask_of(wr_idx_reg);
        end
    end

    // read data, forwarding a write still in its data phase
    always_comb begin
        rd_next = `PPR_RESET_VAL;
        if (addr_hit[3]) begin
            if (wr_pend_reg && wr_idx_reg == addr_hit[2:0]) begin
                rd_next = hwdata & mask_of(wr_idx_reg);
            end else begin
                rd_next = regs_reg[addr_hit[2:0]];
            end
        end
    end

    // bus answer flops; unmapped reads give zero, okay response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= `PPR_RESET_VAL;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_take && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

    // two-stage synchroniser for pads, comparator and low-speed clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_meta_reg <= '0;
            pad_sync_reg <= '0;
        end else begin
            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;
        end
    end
    assign pad_s = pad_sync_reg;

    // field aliases for the multi-set decoders
    assign t1_f  = regs_reg[`PPR_IDX_TIMER][`PPR_T1_F];
    assign t2_f  = regs_reg[`PPR_IDX_TIMER][`PPR_T2_F];
    assign tw2_f = regs_reg[`PPR_IDX_SERIAL][`PPR_TW2_F];
    assign tw1_f = regs_reg[`PPR_IDX_SERIAL][`PPR_TW1_F];
    assign us3_f = regs_reg[`PPR_IDX_UART][`PPR_USART3_F];
    assign sd_f  = regs_reg[`PPR_IDX_UART][`PPR_SD_F];

    // pin-set decode; unused codes fall back to the reset pin set
    always_comb begin
        route_next = '0;
        route_next.fifth_timer_alt = regs_reg[`PPR_IDX_TIMER][`PPR_T5_F] == `PPR_T5_ALT;
        route_next.third_timer_alt = regs_reg[`PPR_IDX_TIMER][`PPR_T3_F] == `PPR_SET1;
        if (t2_f <= `PPR_T2_MAX) begin
            route_next.second_timer_ch12_alt = t2_f[0];
            route_next.second_timer_ch34_alt = t2_f[1];
        end
        if (t1_f <= `PPR_SET2) begin
            route_next.advanced_timer_set = t1_f[1:0];
        end
        route_next.second_spi_alt = regs_reg[`PPR_IDX_SERIAL][`PPR_SPI2_F] == `PPR_SET1;
        route_next.first_spi_alt  = regs_reg[`PPR_IDX_SERIAL][`PPR_SPI1_F] == `PPR_SET1;
        if (tw2_f <= `PPR_SET3) begin
            route_next.second_twowire_set = tw2_f[1:0];
        end
        if (tw1_f <= `PPR_SET2) begin
            route_next.first_twowire_set = tw1_f[1:0];
        end
        route_next.fourth_uart_alt = regs_reg[`PPR_IDX_UART][`PPR_UART4_F] == `PPR_SET1;
        if (us3_f <= `PPR_SET2) begin
            route_next.third_usart_set = us3_f[1:0];
        end
        route_next.first_usart_alt = regs_reg[`PPR_IDX_UART][`PPR_USART1_F] == `PPR_SET1;
        if (sd_f >= `PPR_SD_W8_B && sd_f <= `PPR_SD_W4_A) begin
            route_next.sd_alt           = 1'b1;
            route_next.sd_narrow        = sd_f[0];
            route_next.sd_clkcmd_port_a = sd_f[1];
        end
        route_next.can_alt = regs_reg[`PPR_IDX_UART][`PPR_CAN_F] == `PPR_SET2;
        route_next.osc_pad_port_d_map = regs_reg[`PPR_IDX_DEBUG][`PPR_OSC_BIT];
        case (regs_reg[`PPR_IDX_DEBUG][`PPR_DBG_F])
            `PPR_DBG_NORST: begin
                route_next.jtag_reset_pin_free = 1'b1;
            end
            `PPR_DBG_SWD: begin
                route_next.jtag_reset_pin_free = 1'b1;
                route_next.jtag_pins_free      = 1'b1;
            end
            `PPR_DBG_NONE: begin
                route_next.jtag_reset_pin_free = 1'b1;
                route_next.jtag_pins_free      = 1'b1;
                route_next.swd_pins_free       = 1'b1;
            end
            default: begin
                route_next.jtag_reset_pin_free = 1'b0;
            end
        endcase
    end

    // internal routing; the pin each route uses follows the active pin set
    always_comb begin
        internal_next = '0;
        internal_next.fifth_timer_ch4 = regs_reg[`PPR_IDX_TIMER][`PPR_T5CH4_BIT]
                                        ? pad_s.low_speed_internal_clock : pad_s.pa3;
        internal_next.third_timer_ch1 = comp_route(regs_reg[`PPR_IDX_COMP][`PPR_T3C1_F],
            route_next.third_timer_alt ? pad_s.pb4 : pad_s.pa6, pad_s.cmp_out);
        internal_next.second_timer_ch4 = comp_route(regs_reg[`PPR_IDX_COMP][`PPR_T2C4_F],
            route_next.second_timer_ch34_alt ? pad_s.pb11 : pad_s.pa3, pad_s.cmp_out);
        internal_next.advanced_timer_ch1 = comp_route(regs_reg[`PPR_IDX_COMP][`PPR_T1C1_F],
            route_next.advanced_timer_set[1] ? pad_s.pc6 : pad_s.pa8, pad_s.cmp_out);
        internal_next.advanced_timer_break = comp_route(regs_reg[`PPR_IDX_COMP][`PPR_T1BK_F],
            (route_next.advanced_timer_set == 2'h0) ? pad_s.pb12 : pad_s.pa6, pad_s.cmp_out);
        internal_next.converter_regular_trig = regs_reg[`PPR_IDX_DEBUG][`PPR_ADCREG_BIT]
            ? advanced_timer_trigger_out : ext_interrupt_line_11;
        internal_next.converter_preempt_trig = regs_reg[`PPR_IDX_DEBUG][`PPR_ADCPRE_BIT]
            ? advanced_timer_ch4_out : converter_preempt_default;
    end

    // registered outputs: a field change reaches the ports one edge after it is stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route       <= '0;
            internal_in <= '0;
        end else begin
            route       <= route_next;
            internal_in <= internal_next;
        end
    end

    // checks
    t5_ch4_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> internal_in.fifth_timer_ch4 == ($past(regs_reg[`PPR_IDX_TIMER][`PPR_T5CH4_BIT])
            ? $past(pad_s.low_speed_internal_clock) : $past(pad_s.pa3)))
        else $error("fifth timer ch4 source wrong");
    t3_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs_reg[`PPR_IDX_TIMER][`PPR_T3_F] == `PPR_SET1 && regs_reg[`PPR_IDX_COMP][`PPR_T3C1_F] == 2'h0)
        |=> internal_in.third_timer_ch1 == $past(pad_s.pb4) && route.third_timer_alt)
        else $error("third timer alternate pin not used");
    t2_decode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (t2_f == `PPR_T2_MAX) |=> route.second_timer_ch12_alt && route.second_timer_ch34_alt)
        else $error("second timer code 3 decode wrong");
    t1_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (t1_f > `PPR_SET2) |=> route.advanced_timer_set == 2'h0)
        else $error("advanced timer unused code not ignored");
    sd_narrow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (sd_f == `PPR_SD_W4_A) |=> route.sd_alt && route.sd_narrow && route.sd_clkcmd_port_a)
        else $error("sd code 7 decode wrong");
    debug_none_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs_reg[`PPR_IDX_DEBUG][`PPR_DBG_F] == `PPR_DBG_NONE)
        |=> route.swd_pins_free && route.jtag_pins_free && route.jtag_reset_pin_free)
        else $error("debug release-all decode wrong");
    adc_regular_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !regs_reg[`PPR_IDX_DEBUG][`PPR_ADCREG_BIT]
        |=> internal_in.converter_regular_trig == $past(ext_interrupt_line_11))
        else $error("regular trigger not from interrupt line");
    comp_either_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs_reg[`PPR_IDX_COMP][`PPR_T1BK_F] == `PPR_CMP_EITHER && pad_s.cmp_out)
        |=> internal_in.advanced_timer_break)
        else $error("either setting is not an OR");
    write_effect_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_idx_reg == `PPR_IDX_UART)
        |-> ##2 route.fourth_uart_alt == ($past(hwdata[`PPR_UART4_F], 2) == `PPR_SET1))
        else $error("write did not reach routing in time");
    t5_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> route.fifth_timer_alt == ($past(regs_reg[`PPR_IDX_TIMER][`PPR_T5_F]) == `PPR_T5_ALT))
        else $error("fifth timer pin set wrong");
    spi2_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> route.second_spi_alt == ($past(regs_reg[`PPR_IDX_SERIAL][`PPR_SPI2_F]) == `PPR_SET1))
        else $error("second spi pin set wrong");
    tw2_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tw2_f <= `PPR_SET3) |=> route.second_twowire_set == $past(tw2_f[1:0]))
        else $error("second two-wire pin set wrong");
    tw1_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tw1_f > `PPR_SET2) |=> route.first_twowire_set == 2'h0)
        else $error("first two-wire unused code not ignored");
    us3_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (us3_f > `PPR_SET2) |=> route.third_usart_set == 2'h0)
        else $error("third usart unused code not ignored");
    can_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> route.can_alt == ($past(regs_reg[`PPR_IDX_UART][`PPR_CAN_F]) == `PPR_SET2))
        else $error("can pin set wrong");
    osc_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> route.osc_pad_port_d_map == $past(regs_reg[`PPR_IDX_DEBUG][`PPR_OSC_BIT]))
        else $error("oscillator pad map wrong");
    preempt_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
        regs_reg[`PPR_IDX_DEBUG][`PPR_ADCPRE_BIT] |=> internal_in.converter_preempt_trig == $past(advanced_timer_ch4_out))
        else $error("preempt trigger not from timer channel 4");
    t3_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (regs_reg[`PPR_IDX_COMP][`PPR_T3C1_F] == `PPR_CMP_ONLY) |=> internal_in.third_timer_ch1 == $past(pad_s.cmp_out))
        else $error("third timer ch1 not from comparator");

endmodule
`default_nettype wire

// *** dv/ppr_pad_model.sv ***
// pad and peripheral side model: pad levels, comparator, low-speed clock, timer and interrupt levels
// assumes the bench requests levels; they reach the block just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ppr_pad_model (
    input  wire logic             hclk,      // bus clock
    input  wire logic             hresetn,   // async reset, active low
    input  wire ppr_pkg::ppr_pad_s pad_req,  // requested pad levels
    input  wire logic [3:0]       side_req,  // trigger, ch4, line 11, default
    output var ppr_pkg::ppr_pad_s pad_in,    // toward the pad inputs
    output var logic [3:0]        side_out   // toward the same-clock inputs
);
    import ppr_pkg::*;

    // levels move only after an edge, so the block never sees a change on its sampling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_in   <= '0;
            side_out <= 4'h0;
        end else begin
            pad_in   <= pad_req;
            side_out <= side_req;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench of the pin remap block: registers, pin-set decode, internal routing
// assumes the design package, constants header and pad model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module tb;
    import ppr_pkg::*;
    logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]   haddr = 32'h0;
    logic [1:0]    htrans = 2'h0;
    logic [2:0]    hsize = 3'h2;
    ppr_word_t     hwdata = 32'h0, hrdata, rd;
    wire logic     hreadyout, hresp;
    ppr_route_s    route;
    ppr_internal_s iin;
    ppr_pad_s      pads = '0, pad_in;
    logic [3:0]    side = 4'h0, side_in;
    int            err_count = 0, n_compared = 0;

    // 100 MHz bus clock
    always #5 hclk = ~hclk;

    ppr_pad_model pm (.hclk(hclk), .hresetn(hresetn), .pad_req(pads), .side_req(side),
        .pad_in(pad_in), .side_out(side_in));
    ppr_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .advanced_timer_trigger_out(side_in[3]),
        .advanced_timer_ch4_out(side_in[2]), .ext_interrupt_line_11(side_in[1]),
        .converter_preempt_default(side_in[0]), .route(route), .internal_in(iin));

    task conclude;
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // bounded wait for hready at a rising edge; a hang ends the run
    task edge_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                $display("CHECK FAILED %0t bus hang", $time);
                conclude();
            end
            @(posedge hclk);
        end
    endtask

    // one single transfer: address phase, then data phase; read data taken at its closing edge
    task ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz, input ppr_word_t wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        edge_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        edge_rdy();
        rd = hrdata;
    endtask

    // write a word and let the decode catch up by one edge
    task set(input int i, input ppr_word_t v);
        ahb(1'b1, 32'(i * 4), 3'h2, v);
        @(posedge hclk);
        #1;
    endtask

    // request pad and side levels, then wait past the two-flop synchroniser
    task wpads(input ppr_pad_s p, input logic [3:0] s);
        @(posedge hclk);
        pads <= p;
        side <= s;
        repeat (5) @(posedge hclk);
        #1;
    endtask

    task t_regs;
        ppr_word_t m [5];
        m = '{`PPR_MASK_TIMER, `PPR_MASK_SERIAL, `PPR_MASK_UART, `PPR_MASK_DEBUG, `PPR_MASK_COMP};
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, 32'(i * 4), 3'h2, 32'h0);
            `CHK(rd, 32'h0)
            ahb(1'b1, 32'(i * 4), 3'h0, 32'hFFFF_FFFF);
            ahb(1'b0, 32'(i * 4), 3'h2, 32'h0);
            `CHK(rd, 32'h0)
            ahb(1'b1, 32'(i * 4), 3'h2, 32'hFFFF_FFFF);
            ahb(1'b0, 32'(i * 4), 3'h2, 32'h0);
            `CHK(rd, (i < 5) ? m[i] : 32'h0)
            `CHK(hresp, 1'b0)
            `CHK(hreadyout, 1'b1)
            ahb(1'b1, 32'(i * 4), 3'h2, 32'h0);
        end
    endtask

    task t_route;
        logic [2:0] dc [4];
        logic [2:0] de [4];
        dc = '{3'h1, 3'h2, 3'h4, 3'h3};
        de = '{3'h4, 3'h6, 3'h7, 3'h0};
        set(0, 32'h0001_0132);
        `CHK(route.fifth_timer_alt, 1'b1)
        `CHK(route.third_timer_alt, 1'b1)
        `CHK({route.second_timer_ch12_alt, route.second_timer_ch34_alt}, 2'h3)
        `CHK(route.advanced_timer_set, 2'h2)
        set(0, 32'h0000_0013);
        `CHK({route.second_timer_ch12_alt, route.second_timer_ch34_alt}, 2'h2)
        `CHK(route.advanced_timer_set, 2'h0)
        set(1, 32'h0011_0320);
        `CHK(route.second_spi_alt, 1'b1)
        `CHK(route.first_spi_alt, 1'b1)
        `CHK(route.second_twowire_set, 2'h3)
        `CHK(route.first_twowire_set, 2'h2)
        set(2, 32'h1201_0702);
        `CHK(route.fourth_uart_alt, 1'b1)
        `CHK(route.third_usart_set, 2'h2)
        `CHK(route.first_usart_alt, 1'b1)
        `CHK({route.sd_alt, route.sd_narrow, route.sd_clkcmd_port_a}, 3'h7)
        `CHK(route.can_alt, 1'b1)
        set(2, 32'h0000_0401);
        `CHK({route.sd_alt, route.sd_narrow, route.sd_clkcmd_port_a}, 3'h4)
        `CHK(route.can_alt, 1'b0)
        set(2, 32'h0000_0300);
        `CHK({route.sd_alt, route.sd_narrow, route.sd_clkcmd_port_a}, 3'h0)
        set(3, 32'h0010_0000);
        `CHK(route.osc_pad_port_d_map, 1'b1)
        for (int i = 0; i < 4; i++) begin
            set(3, {13'h0, dc[i], 16'h0});
            `CHK({route.jtag_reset_pin_free, route.jtag_pins_free, route.swd_pins_free}, de[i])
        end
    endtask

    // every comparator code against every pin/comparator level pair
    task t_cmp;
        logic       e;
        logic [3:0] got;
        set(0, 32'h0);
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 2; p++) begin
                for (int m = 0; m < 2; m++) begin
                    set(4, {24'h0, {4{2'(c)}}});
                    wpads({1'(p), 1'(p), 1'(p), 2'h0, 1'(p), 1'b0, 1'(m), 1'b0}, 4'h0);
                    e = (c < 2) ? 1'(p) : ((c == 2) ? 1'(m) : 1'(p | m));
                    got = {iin.third_timer_ch1, iin.second_timer_ch4, iin.advanced_timer_ch1, iin.advanced_timer_break};
                    `CHK(got, {4{e}})
                end
            end
        end
        set(4, 32'h0);
        set(0, 32'h0000_0101);
        wpads(9'h028, 4'h0);
        `CHK(iin.third_timer_ch1, 1'b1)
        `CHK(iin.advanced_timer_break, 1'b0)
    endtask

    task t_trig;
        set(0, 32'h0);
        set(3, 32'h0);
        wpads(9'h100, 4'h2);
        `CHK(iin.fifth_timer_ch4, 1'b1)
        `CHK(iin.converter_regular_trig, 1'b1)
        `CHK(iin.converter_preempt_trig, 1'b0)
        set(0, 32'h0008_0000);
        set(3, 32'h0000_0030);
        wpads(9'h100, 4'h4);
        `CHK(iin.fifth_timer_ch4, 1'b0)
        `CHK(iin.converter_regular_trig, 1'b0)
        `CHK(iin.converter_preempt_trig, 1'b1)
        wpads(9'h001, 4'h8);
        `CHK(iin.fifth_timer_ch4, 1'b1)
        `CHK(iin.converter_regular_trig, 1'b1)
        `CHK(iin.converter_preempt_trig, 1'b0)
    endtask

    // reset for three cycles, then each scenario in turn
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_route();
        t_cmp();
        t_trig();
        conclude();
    end
endmodule
`default_nettype wire
